// file: inc/mea_pkg.sv
// constants shared by the motion event aggregator files
// assumes a 32-bit APB slave with word-indexed registers
package mea_pkg;
	// printed offsets are word indices, byte address is four times the index
	localparam int IDX_SPI_SEL = 'h0b;
	localparam int IDX_PROTECT = 'h0c;
	localparam int IDX_IRQ_SEL = 'h0d;
	localparam int IDX_EVENTS = 'h0e;
	localparam int IDX_CTRL = 'h10;
	localparam int IDX_SYS_STAT = 'h11;
	localparam int IDX_SYS_MASK = 'h12;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SPD_W = 32;
	localparam int STAT_W = 8;
	localparam int SYS_W = 3;

	// reset values
	localparam logic [31:0] RST_SPI_SEL = 32'h8202_9805;
	localparam logic [31:0] RST_PROTECT = 32'h0000_0000;
	localparam logic [31:0] RST_IRQ_SEL = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL = 32'h0000_0001;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// event bit positions
	localparam int EV_TARGET = 0;
	localparam int EV_POSCMP = 1;
	localparam int EV_TOPSPD = 2;
	localparam int EV_SPD_ZERO = 3;
	localparam int EV_SPD_POS = 4;
	localparam int EV_SPD_NEG = 5;
	localparam int EV_RAMP_CONST = 6;
	localparam int EV_RAMP_UP = 7;
	localparam int EV_RAMP_B10 = 8;
	localparam int EV_TRAP_MAX = 9;
	localparam int EV_HALT = 10;
	localparam int EV_LEFT = 11;
	localparam int EV_COUNT = 12;

	// state codes; CODE_NONE is the previous value after reset
	localparam logic [1:0] CODE_00 = 2'h0;
	localparam logic [1:0] CODE_01 = 2'h1;
	localparam logic [1:0] CODE_10 = 2'h2;
	localparam logic [1:0] CODE_NONE = 2'h3;

	// control and block status fields
	localparam int CTRL_LEFT_EN = 0;
	localparam int SYS_HALT = 0;
	localparam int SYS_LEFT_BLK = 1;
	localparam int SYS_ANY_EV = 2;

	typedef enum logic [1:0] {
		APB_IDLE = 2'b01,
		APB_RESP = 2'b10
	} mea_apb_state_type;
endpackage : mea_pkg

// file: rtl/mea_event_detect.sv
// edge and change detection for the motion event sources
// assumes every source is synchronous to pclk
`timescale 1ns/10ps
module mea_event_detect import mea_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// motion core conditions
	input wire logic target_reached,
	input wire logic pos_comp_reached,
	input wire logic top_speed_hit,
	input wire logic [1:0] speed_sign_code,
	input wire logic [1:0] ramp_state_code,
	input wire logic trap_ramp_mode,
	input wire logic signed [SPD_W-1:0] present_speed,
	input wire logic signed [SPD_W-1:0] present_accel,
	input wire logic [SPD_W-1:0] peak_accel,
	input wire logic [SPD_W-1:0] peak_decel,
	input wire logic [SPD_W-1:0] break_speed,
	input wire logic halt_in_n,
	input wire logic left_limit_switch,
	input wire logic left_en,
	// one-cycle set requests
	output logic [EV_COUNT-1:0] set_vec
);
	function automatic logic [SPD_W-1:0] magnitude(input logic signed [SPD_W-1:0] v);
		magnitude = v[SPD_W-1] ? SPD_W'(-v) : SPD_W'(v);
	endfunction : magnitude

	logic [2:0] lvl_prev_r;
	logic [1:0] sign_prev_r;
	logic [1:0] ramp_prev_r;
	logic trap_prev_r;
	logic halt_prev_r;
	logic left_prev_r;

	wire [2:0] lvl_now = {top_speed_hit, pos_comp_reached, target_reached};
	wire [SPD_W-1:0] spd_mag = magnitude(present_speed);
	wire [SPD_W-1:0] acc_mag = magnitude(present_accel);
	wire at_peak = (acc_mag == peak_accel) || (acc_mag == peak_decel);
	wire trap_now = trap_ramp_mode && at_peak && (break_speed != '0) && (spd_mag > break_speed);
	wire left_now = left_limit_switch && left_en;
	wire sign_new = speed_sign_code != sign_prev_r;
	wire ramp_new = ramp_state_code != ramp_prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_prev_r <= 3'h0;
			sign_prev_r <= CODE_NONE;
			ramp_prev_r <= CODE_NONE;
			trap_prev_r <= 1'b0;
			halt_prev_r <= 1'b1;
			left_prev_r <= 1'b0;
		end else begin
			lvl_prev_r <= lvl_now;
			sign_prev_r <= speed_sign_code;
			ramp_prev_r <= ramp_state_code;
			trap_prev_r <= trap_now;
			halt_prev_r <= halt_in_n;
			left_prev_r <= left_now;
		end
	end

	assign set_vec[EV_TOPSPD:EV_TARGET] = lvl_now & ~lvl_prev_r;
	assign set_vec[EV_SPD_ZERO] = sign_new && (speed_sign_code == CODE_00);
	assign set_vec[EV_SPD_POS] = sign_new && (speed_sign_code == CODE_01);
	assign set_vec[EV_SPD_NEG] = sign_new && (speed_sign_code == CODE_10);
	assign set_vec[EV_RAMP_CONST] = ramp_new && (ramp_state_code == CODE_00);
	assign set_vec[EV_RAMP_UP] = ramp_new && (ramp_state_code == CODE_01);
	assign set_vec[EV_RAMP_B10] = ramp_new && (ramp_state_code == CODE_10);
	assign set_vec[EV_TRAP_MAX] = trap_now && !trap_prev_r;
	assign set_vec[EV_HALT] = halt_prev_r && !halt_in_n;
	assign set_vec[EV_LEFT] = left_now && !left_prev_r;
endmodule : mea_event_detect

// file: rtl/mea_top.sv
// motion event aggregator: sticky events, masks, APB registers, irq
// assumes an APB master on pclk and motion sources synchronous to pclk
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
module mea_top import mea_pkg::*; #(
	parameter int N_EVENTS = EV_COUNT
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// motion core conditions
	input wire logic target_reached,
	input wire logic pos_comp_reached,
	input wire logic top_speed_hit,
	input wire logic [1:0] speed_sign_code,
	input wire logic [1:0] ramp_state_code,
	input wire logic trap_ramp_mode,
	input wire logic signed [SPD_W-1:0] present_speed,
	input wire logic signed [SPD_W-1:0] present_accel,
	input wire logic [SPD_W-1:0] peak_accel,
	input wire logic [SPD_W-1:0] peak_decel,
	input wire logic [SPD_W-1:0] break_speed,
	input wire logic halt_in_n,
	input wire logic left_limit_switch,
	// block outputs
	output logic [STAT_W-1:0] spi_status,
	output logic irq_out,
	output logic motion_halt,
	output logic neg_motion_block
);
	generate
		if (N_EVENTS != EV_COUNT) begin : g_bad_width
			$error("mea_top: N_EVENTS must equal the defined event count");
		end
	endgenerate

	function automatic logic hit(input logic [ADDR_W-1:0] a, input int idx);
		hit = a == ADDR_W'(idx * 4);
	endfunction : hit

	mea_apb_state_type state_r, state_nxt;
	logic [DATA_W-1:0] spi_sel_r, protect_r, irq_sel_r, ctrl_r;
	logic [N_EVENTS-1:0] events_r, events_nxt;
	logic [SYS_W-1:0] sys_stat_r, sys_stat_nxt, sys_mask_r;
	logic [DATA_W-1:0] prdata_r;
	logic pready_r, pslverr_r;
	logic [STAT_W-1:0] spi_status_r;
	logic irq_out_r, motion_halt_r, neg_block_r, neg_block_nxt;
	logic [N_EVENTS-1:0] set_vec;

	// bus decode
	wire access = psel && penable;
	wire start = access && (state_r == APB_IDLE);
	wire done = access && (state_r == APB_RESP);
	wire sel_spi = hit(paddr, IDX_SPI_SEL);
	wire sel_prot = hit(paddr, IDX_PROTECT);
	wire sel_isel = hit(paddr, IDX_IRQ_SEL);
	wire sel_ev = hit(paddr, IDX_EVENTS);
	wire sel_ctrl = hit(paddr, IDX_CTRL);
	wire sel_sst = hit(paddr, IDX_SYS_STAT);
	wire sel_smsk = hit(paddr, IDX_SYS_MASK);
	wire mapped = sel_spi | sel_prot | sel_isel | sel_ev | sel_ctrl | sel_sst | sel_smsk;
	wire wr_done = done && pwrite && !pslverr_r;
	wire rd_ev_done = done && !pwrite && sel_ev;
	wire [DATA_W-1:0] ev_word = DATA_W'(events_r);

	wire [DATA_W-1:0] rd_mux =
		sel_spi ? spi_sel_r :
		sel_prot ? protect_r :
		sel_isel ? irq_sel_r :
		sel_ev ? ev_word :
		sel_ctrl ? ctrl_r :
		sel_sst ? DATA_W'(sys_stat_r) :
		sel_smsk ? DATA_W'(sys_mask_r) : '0;

	assign state_nxt = start ? APB_RESP : (done ? APB_IDLE : state_r);

	// only what the read returned is cleared; later sets survive the read
	wire [N_EVENTS-1:0] clr_vec = rd_ev_done ?
		(prdata_r[N_EVENTS-1:0] & ~protect_r[N_EVENTS-1:0]) : '0;
	assign events_nxt = (events_r & ~clr_vec) | set_vec;

	wire [STAT_W-1:0] spi_pick = ev_word[STAT_W-1:0] & spi_sel_r[STAT_W-1:0];
	wire ev_irq = |(ev_word & irq_sel_r);
	wire sys_irq = |(sys_stat_r & sys_mask_r);

	wire left_en = ctrl_r[CTRL_LEFT_EN];
	wire left_release = !events_r[EV_LEFT] && (!left_limit_switch || !left_en);
	assign neg_block_nxt = set_vec[EV_LEFT] ? 1'b1 :
		(left_release ? 1'b0 : neg_block_r);

	wire [SYS_W-1:0] sys_set = {|set_vec, set_vec[EV_LEFT], set_vec[EV_HALT]};
	wire [SYS_W-1:0] sys_clr = (wr_done && sel_sst) ? pwdata[SYS_W-1:0] : '0;
	// a fresh set beats a write-one clear in the same cycle
	assign sys_stat_nxt = (sys_stat_r & ~sys_clr) | sys_set;

	mea_event_detect u_detect (
		.pclk(pclk),
		.presetn(presetn),
		.target_reached(target_reached),
		.pos_comp_reached(pos_comp_reached),
		.top_speed_hit(top_speed_hit),
		.speed_sign_code(speed_sign_code),
		.ramp_state_code(ramp_state_code),
		.trap_ramp_mode(trap_ramp_mode),
		.present_speed(present_speed),
		.present_accel(present_accel),
		.peak_accel(peak_accel),
		.peak_decel(peak_decel),
		.break_speed(break_speed),
		.halt_in_n(halt_in_n),
		.left_limit_switch(left_limit_switch),
		.left_en(left_en),
		.set_vec(set_vec)
	);

	// bus handshake: one wait cycle so that read data comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= APB_IDLE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= RST_ZERO;
		end else begin
			state_r <= state_nxt;
			pready_r <= start;
			pslverr_r <= start && !mapped;
			if (start) begin
				prdata_r <= pwrite ? RST_ZERO : rd_mux;
			end
		end
	end

	// software written registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spi_sel_r <= RST_SPI_SEL;
			protect_r <= RST_PROTECT;
			irq_sel_r <= RST_IRQ_SEL;
			ctrl_r <= RST_CTRL;
			sys_mask_r <= '0;
		end else if (wr_done) begin
			if (sel_spi) spi_sel_r <= pwdata;
			if (sel_prot) protect_r <= pwdata;
			if (sel_isel) irq_sel_r <= pwdata;
			if (sel_ctrl) ctrl_r <= pwdata & RST_CTRL;
			if (sel_smsk) sys_mask_r <= pwdata[SYS_W-1:0];
		end
	end

	// event state and registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			events_r <= '0;
			sys_stat_r <= '0;
			spi_status_r <= '0;
			irq_out_r <= 1'b0;
			motion_halt_r <= 1'b0;
			neg_block_r <= 1'b0;
		end else begin
			events_r <= events_nxt;
			sys_stat_r <= sys_stat_nxt;
			spi_status_r <= spi_pick;
			irq_out_r <= ev_irq || sys_irq;
			// only a reset lets motion resume after a halt
			motion_halt_r <= motion_halt_r || set_vec[EV_HALT];
			neg_block_r <= neg_block_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign spi_status = spi_status_r;
	assign irq_out = irq_out_r;
	assign motion_halt = motion_halt_r;
	assign neg_motion_block = neg_block_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_req_taken;
		psel && penable && !pready_r;
	endsequence

	sequence s_ev_read;
		psel && penable && pready_r && !pwrite && sel_ev;
	endsequence

	a_apb_answer: assert property (s_req_taken |=> pready_r ##1 !pready_r)
		else $error("apb answer not one cycle after access");

	a_spi_forward: assert property (1'b1 |=> spi_status_r ==
		($past(ev_word[STAT_W-1:0]) & $past(spi_sel_r[STAT_W-1:0])))
		else $error("spi status does not follow selected events");

	a_read_clears: assert property (s_ev_read |=> ((events_r &
		$past(prdata_r[N_EVENTS-1:0]) & ~$past(protect_r[N_EVENTS-1:0]) &
		~$past(set_vec)) == '0))
		else $error("read event bit not cleared");

	a_protect_keeps: assert property (s_ev_read |=>
		(($past(events_r) & $past(protect_r[N_EVENTS-1:0]) & ~events_r) == '0))
		else $error("protected event lost on read");

	a_irq_or: assert property (ev_irq |=> irq_out_r)
		else $error("selected event gave no interrupt");

	a_irq_quiet: assert property (!ev_irq && !sys_irq |=> !irq_out_r)
		else $error("interrupt without cause");

	a_sign_pos: assert property ($changed(speed_sign_code) && speed_sign_code == CODE_01
		|=> events_r[EV_SPD_POS])
		else $error("positive speed event missing");

	a_ramp_b10: assert property ($changed(ramp_state_code) && ramp_state_code == CODE_10
		|=> events_r[EV_RAMP_B10])
		else $error("ramp code 10 event missing");

	a_trap_event: assert property (set_vec[EV_TRAP_MAX] |-> break_speed != '0
		##1 events_r[EV_TRAP_MAX])
		else $error("trapezoid limit event wrong");

	a_halt_latch: assert property ($fell(halt_in_n) |=> events_r[EV_HALT] && motion_halt_r
		##1 motion_halt_r [*3])
		else $error("halt not latched");

	a_left_block: assert property (neg_block_r && events_r[EV_LEFT] |=> neg_block_r)
		else $error("negative block released while event set");

	a_target_event: assert property ($rose(target_reached) |=> events_r[EV_TARGET])
		else $error("target event missing");

	a_sticky_bit: assert property (events_r[EV_TOPSPD] && !rd_ev_done
		|=> events_r[EV_TOPSPD])
		else $error("event bit dropped without read");
endmodule : mea_top

// file: tb/mea_motion_model.sv
// motion source stand-in that drives the event inputs of the aggregator
// assumes one request at a time from the bench, synchronous to pclk
`timescale 1ns/10ps
module mea_motion_model import mea_pkg::*; (
	// clock
	input wire logic pclk,
	// bench request
	input wire logic go,
	input wire logic [3:0] sel,
	// motion conditions
	output logic target_reached,
	output logic pos_comp_reached,
	output logic top_speed_hit,
	output logic [1:0] speed_sign_code,
	output logic [1:0] ramp_state_code,
	output logic trap_ramp_mode,
	output logic signed [SPD_W-1:0] present_speed,
	output logic signed [SPD_W-1:0] present_accel,
	output logic [SPD_W-1:0] peak_accel,
	output logic [SPD_W-1:0] peak_decel,
	output logic [SPD_W-1:0] break_speed,
	output logic halt_in_n,
	output logic left_limit_switch
);
	logic [2:0] cnt_r = 3'h0;
	logic [3:0] sel_r = 4'hf;
	logic act;
	// codes idle at 11, which names no event, so nothing fires before a request
	logic [1:0] spd_r = 2'h3;
	logic [1:0] rmp_r = 2'h3;
	always @(posedge pclk) begin
		if (go) begin
			sel_r <= sel;
			cnt_r <= 3'h3;
		end else if (cnt_r != 3'h0) begin
			cnt_r <= cnt_r - 3'h1;
		end
		if (go && sel >= 4'h3 && sel <= 4'h5) begin
			spd_r <= 2'(sel - 4'h3);
		end
		if (go && sel >= 4'h6 && sel <= 4'h8) begin
			rmp_r <= 2'(sel - 4'h6);
		end
	end
	// conditions other than the two codes are short pulses so stickiness is exercised
	assign act = cnt_r != 3'h0;
	assign target_reached = act && sel_r == 4'h0;
	assign pos_comp_reached = act && sel_r == 4'h1;
	assign top_speed_hit = act && sel_r == 4'h2;
	assign speed_sign_code = spd_r;
	assign ramp_state_code = rmp_r;
	assign trap_ramp_mode = act && sel_r == 4'h9;
	assign halt_in_n = !(act && sel_r == 4'ha);
	assign left_limit_switch = act && sel_r == 4'hb;
	// negative accel checks that the magnitude is compared
	assign present_speed = 32'sh0000_03e8;
	assign present_accel = -32'sh0000_0064;
	assign peak_accel = 32'h0000_0064;
	assign peak_decel = 32'h0000_00c8;
	assign break_speed = 32'h0000_0032;
endmodule : mea_motion_model

// file: tb/motion_event_aggregator_tb_top.sv
// self-checking bench for the motion event aggregator
// assumes the motion model as source and the pready-paced APB access of the slave
`timescale 1ns/10ps
module motion_event_aggregator_tb_top import mea_pkg::*;;
	typedef struct {
		logic [31:0] d;
		logic e;
		logic rd;
	} mea_note_type;
	localparam logic RD = 1'b0;
	localparam logic WR = 1'b1;
	localparam logic [31:0] Z = 32'h0000_0000;
	localparam logic [7:0] A_SPI = 8'(IDX_SPI_SEL * 4);
	localparam logic [7:0] A_EV = 8'(IDX_EVENTS * 4);
	localparam logic [7:0] A_CTRL = 8'(IDX_CTRL * 4);
	localparam logic [31:0] IRQM = 32'h0000_0a5a;
	localparam logic [31:0] RSTV [3] = '{RST_SPI_SEL, RST_PROTECT, RST_IRQ_SEL};
	logic pclk = 1'b0;
	logic presetn, psel, penable, pwrite, pready, pslverr, go;
	logic [7:0] paddr, spi_status, a;
	logic [31:0] pwdata, prdata, rv, ev;
	logic [3:0] sel;
	logic target_reached, pos_comp_reached, top_speed_hit, trap_ramp_mode;
	logic [1:0] speed_sign_code, ramp_state_code;
	logic signed [SPD_W-1:0] present_speed, present_accel;
	logic [SPD_W-1:0] peak_accel, peak_decel, break_speed;
	logic halt_in_n, left_limit_switch, irq_out, motion_halt, neg_motion_block;
	mea_note_type notes[$];
	mea_note_type note;
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 32'h0a1a_a033;

	mea_top i_mea_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .target_reached, .pos_comp_reached, .top_speed_hit,
		.speed_sign_code, .ramp_state_code, .trap_ramp_mode, .present_speed, .present_accel,
		.peak_accel, .peak_decel, .break_speed, .halt_in_n, .left_limit_switch,
		.spi_status, .irq_out, .motion_halt, .neg_motion_block);
	mea_motion_model i_mea_motion_model (.pclk, .go, .sel, .target_reached,
		.pos_comp_reached, .top_speed_hit, .speed_sign_code, .ramp_state_code,
		.trap_ramp_mode, .present_speed, .present_accel, .peak_accel, .peak_decel,
		.break_speed, .halt_in_n, .left_limit_switch);

	initial forever #25 pclk = ~pclk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// the note is queued before the request so the monitor never runs dry
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
		input logic [31:0] x, input logic err);
		notes.push_back('{x, err, !w});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle count assumed; only the watchdog ends a stuck wait
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic trig(input int i);
		go <= 1'b1;
		sel <= 4'(i);
		@(posedge pclk);
		go <= 1'b0;
		repeat (6) @(posedge pclk);
	endtask : trig

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done

	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			if (notes.size() == 0) begin
				chk("unexpected answer", Z, 32'h1);
			end else begin
				note = notes.pop_front();
				if (note.rd) begin
					chk("prdata", note.d, prdata);
				end
				chk("pslverr", 32'(note.e), 32'(pslverr));
			end
		end
	end

	initial begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		test_done();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = Z;
		go = 1'b0;
		sel = 4'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(RD, A_CTRL, Z, RST_CTRL, 1'b0);
		apb(RD, 8'hfc, Z, Z, 1'b1);
		apb(WR, 8'hf0, 32'hffff_ffff, Z, 1'b1);
		for (int k = 0; k < 3; k++) begin
			a = A_SPI + 8'(4 * k);
			rv = $random(seed);
			apb(RD, a, Z, RSTV[k], 1'b0);
			apb(WR, a, rv, Z, 1'b0);
			apb(RD, a, Z, rv, 1'b0);
			apb(WR, a, RSTV[k], Z, 1'b0);
		end
		apb(WR, A_SPI + 8'h08, IRQM, Z, 1'b0);
		apb(RD, A_EV, Z, Z, 1'b0);
		for (int i = 0; i < EV_COUNT; i++) begin
			ev = 32'h1 << i;
			trig(i);
			chk("spi_status", 32'(ev[7:0] & RST_SPI_SEL[7:0]), 32'(spi_status));
			chk("irq_out", 32'(|(ev & IRQM)), 32'(irq_out));
			chk("motion_halt", 32'(i >= EV_HALT), 32'(motion_halt));
			chk("neg block", 32'(i == EV_LEFT), 32'(neg_motion_block));
			apb(RD, A_EV, Z, ev, 1'b0);
			@(posedge pclk);
			chk("irq_out", Z, 32'(irq_out));
			chk("spi_status", Z, 32'(spi_status));
			chk("neg block", Z, 32'(neg_motion_block));
		end
		apb(WR, A_SPI + 8'h04, 32'h0000_0001, Z, 1'b0);
		trig(EV_TARGET);
		apb(RD, A_EV, Z, 32'h0000_0001, 1'b0);
		apb(RD, A_EV, Z, 32'h0000_0001, 1'b0);
		apb(WR, A_SPI + 8'h04, Z, Z, 1'b0);
		apb(RD, A_EV, Z, 32'h0000_0001, 1'b0);
		apb(RD, A_EV, Z, Z, 1'b0);
		apb(WR, A_EV, 32'hffff_ffff, Z, 1'b0);
		apb(RD, A_EV, Z, Z, 1'b0);
		// left limit with its enable cleared must not fire or block
		apb(WR, A_CTRL, Z, Z, 1'b0);
		apb(RD, A_CTRL, Z, Z, 1'b0);
		trig(EV_LEFT);
		chk("neg block", Z, 32'(neg_motion_block));
		apb(RD, A_EV, Z, Z, 1'b0);
		apb(WR, A_CTRL, RST_CTRL, Z, 1'b0);
		// block status holds halt, left and any-event since nothing cleared it
		apb(RD, 8'(IDX_SYS_STAT * 4), Z, 32'h0000_0007, 1'b0);
		apb(WR, 8'(IDX_SYS_MASK * 4), 32'h0000_0004, Z, 1'b0);
		@(posedge pclk);
		chk("irq_out", 32'h1, 32'(irq_out));
		apb(WR, 8'(IDX_SYS_STAT * 4), 32'h0000_0007, Z, 1'b0);
		@(posedge pclk);
		chk("irq_out", Z, 32'(irq_out));
		chk("motion_halt", 32'h1, 32'(motion_halt));
		// only a reset releases the halt
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("motion_halt", Z, 32'(motion_halt));
		presetn <= 1'b1;
		@(posedge pclk);
		// codes still stand at 10, so both code events fire after reset
		apb(RD, A_EV, Z, 32'h0000_0120, 1'b0);
		apb(RD, A_SPI, Z, RST_SPI_SEL, 1'b0);
		chk("notes left", Z, 32'(notes.size()));
		test_done();
	end
endmodule : motion_event_aggregator_tb_top
